/* File: design/ddir_pkg.sv */
// constants and types for the divide, increment and re-init datapath
// assumes one 10 MHz clock and a synchronous, active-low reset
package ddir_pkg;
  localparam int unsigned ACC_W = 32;
  localparam logic [ACC_W-1:0] ACC_ZERO = 32'h0000_0000;
  localparam logic [ACC_W-1:0] ACC_ONE = 32'h0000_0001;
  localparam logic [ACC_W-1:0] ACC_SMAX = 32'h7FFF_FFFF;
  // instruction codes on the command port
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_DIV = 2'h1;
  localparam logic [1:0] OP_INC = 2'h2;
  localparam logic [1:0] OP_INIT = 2'h3;
  // working register select
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  localparam logic [1:0] SEL_R = 2'h2;
  // flag vector layout {c, o, s, z}
  localparam int unsigned FLAG_W = 4;
  localparam int unsigned FLAG_C = 3;
  localparam int unsigned FLAG_O = 2;
  localparam int unsigned FLAG_S = 1;
  localparam int unsigned FLAG_Z = 0;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
  // configuration copy from non-volatile memory
  localparam int unsigned CFG_AW = 6;
  localparam logic [CFG_AW-1:0] CFG_LAST = 6'h3F;
  localparam logic [CFG_AW-1:0] CNT_ZERO = 6'h00;
  localparam int unsigned CFG_DW = 8;
  localparam logic [CFG_DW-1:0] CFG_DZERO = 8'h00;
  // converter and core reset hold
  localparam real CLK_MHZ = 10.0;
  localparam real RST_HOLD_NS = 400.0;
  localparam logic [CFG_AW-1:0] RST_HOLD_CYC =
    CFG_AW'($ceil(RST_HOLD_NS * CLK_MHZ / 1000.0));
  typedef enum logic [1:0] {
    DDIR_IDLE = 2'b00,
    DDIR_RST  = 2'b01,
    DDIR_COPY = 2'b11,
    DDIR_LAST = 2'b10
  } ddir_state_t;
endpackage : ddir_pkg

/* File: design/ddir_alu_if.sv */
// bundle between the sequencing core and the arithmetic module
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
interface ddir_alu_if;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] r;
  logic [1:0]  sel;
  logic [31:0] div_a;
  logic [31:0] div_b;
  logic        div_s;
  logic        div_z;
  logic [31:0] inc_val;
  logic        inc_c;
  logic        inc_o;
  logic        inc_s;
  logic        inc_z;
  modport alu (input a, b, r, sel,
               output div_a, div_b, div_s, div_z,
                      inc_val, inc_c, inc_o, inc_s, inc_z);
  modport core (output a, b, r, sel,
                input div_a, div_b, div_s, div_z,
                      inc_val, inc_c, inc_o, inc_s, inc_z);
endinterface : ddir_alu_if

/* File: design/ddir_alu.sv */
// combinational divide step and increment
// assumes the caller holds operands stable for the cycle it samples
`timescale 1ns/100ps
module ddir_alu (
  ddir_alu_if.alu bus
);
  wire             fits;
  wire [31:0]      diff;
  wire [31:0]      src;
  wire [32:0]      sum;
  // restoring step: quotient bit enters b, remainder doubles in a
  assign fits = (bus.a >= bus.r);
  assign diff = fits ? (bus.a - bus.r) : bus.a;
  assign bus.div_a = {diff[30:0], 1'b0};
  assign bus.div_b = {bus.b[30:0], fits};
  assign bus.div_s = bus.div_b[31];
  assign bus.div_z = (bus.div_b == ddir_pkg::ACC_ZERO);
  assign src = (bus.sel == ddir_pkg::SEL_A) ? bus.a :
               (bus.sel == ddir_pkg::SEL_B) ? bus.b : bus.r;
  assign sum = {1'b0, src} + {1'b0, ddir_pkg::ACC_ONE};
  assign bus.inc_val = sum[31:0];
  assign bus.inc_c = sum[32];
  assign bus.inc_o = (src == ddir_pkg::ACC_SMAX);
  assign bus.inc_s = sum[31];
  assign bus.inc_z = (sum[31:0] == ddir_pkg::ACC_ZERO);
endmodule : ddir_alu

/* File: design/ddir_core.sv */
// divide step, increment and re-initialisation of the working registers
// assumes firmware issues one command at a time while busy_o is low and
// that the non-volatile memory answers a read on the following cycle
`timescale 1ns/100ps
module ddir_core (
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          op_valid_i,
  input  wire logic [1:0]                    op_code_i,
  input  wire logic [1:0]                    op_sel_i,
  input  wire logic                          wr_en_i,
  input  wire logic [1:0]                    wr_sel_i,
  input  wire logic [31:0]                   wr_data_i,
  input  wire logic [ddir_pkg::CFG_DW-1:0]   nv_data_i,
  output logic      [31:0]                   acc_a_o,
  output logic      [31:0]                   acc_b_o,
  output logic      [31:0]                   acc_r_o,
  output logic      [ddir_pkg::FLAG_W-1:0]   flags_o,
  output logic                               busy_o,
  output logic                               done_o,
  output logic                               cdc_reset_o,
  output logic                               resistance_converter_reset_o,
  output logic                               cpu_reset_o,
  output logic                               nv_rd_o,
  output logic      [ddir_pkg::CFG_AW-1:0]   nv_addr_o,
  output logic                               cfg_we_o,
  output logic      [ddir_pkg::CFG_AW-1:0]   cfg_addr_o,
  output logic      [ddir_pkg::CFG_DW-1:0]   cfg_data_o
);
  ddir_pkg::ddir_state_t state;
  ddir_pkg::ddir_state_t next_state;
  logic [31:0]                 acc_a;
  logic [31:0]                 acc_b;
  logic [31:0]                 acc_r;
  logic [ddir_pkg::FLAG_W-1:0] flags;
  logic [ddir_pkg::CFG_AW-1:0] cnt;
  logic [ddir_pkg::CFG_AW-1:0] next_cnt;
  logic                        rd_q;
  logic [ddir_pkg::CFG_AW-1:0] rd_addr_q;

  ddir_alu_if alu_bus ();

  ddir_alu u_alu (
    .bus (alu_bus.alu)
  );

  wire idle     = (state == ddir_pkg::DDIR_IDLE);
  wire op_go    = op_valid_i && idle;
  wire do_div   = op_go && (op_code_i == ddir_pkg::OP_DIV);
  wire do_inc   = op_go && (op_code_i == ddir_pkg::OP_INC);
  wire do_init  = op_go && (op_code_i == ddir_pkg::OP_INIT);
  wire wr_go    = wr_en_i && idle && !op_go;
  wire in_rst   = (state == ddir_pkg::DDIR_RST);
  wire in_copy  = (state == ddir_pkg::DDIR_COPY);
  wire rst_end  = in_rst && (cnt == ddir_pkg::RST_HOLD_CYC);
  wire copy_end = in_copy && (cnt == ddir_pkg::CFG_LAST);
  wire inc_a    = do_inc && (op_sel_i == ddir_pkg::SEL_A);
  wire inc_b    = do_inc && (op_sel_i == ddir_pkg::SEL_B);
  wire inc_r    = do_inc && (op_sel_i != ddir_pkg::SEL_A) &&
                  (op_sel_i != ddir_pkg::SEL_B);
  wire wr_a     = wr_go && (wr_sel_i == ddir_pkg::SEL_A);
  wire wr_b     = wr_go && (wr_sel_i == ddir_pkg::SEL_B);
  wire wr_r     = wr_go && (wr_sel_i == ddir_pkg::SEL_R);

  assign alu_bus.a   = acc_a;
  assign alu_bus.b   = acc_b;
  assign alu_bus.r   = acc_r;
  assign alu_bus.sel = op_sel_i;

  // operand selection per register
  wire [31:0] next_a = in_rst ? ddir_pkg::ACC_ZERO :
                       do_div ? alu_bus.div_a :
                       inc_a  ? alu_bus.inc_val :
                       wr_a   ? wr_data_i : acc_a;
  wire [31:0] next_b = in_rst ? ddir_pkg::ACC_ZERO :
                       do_div ? alu_bus.div_b :
                       inc_b  ? alu_bus.inc_val :
                       wr_b   ? wr_data_i : acc_b;
  wire [31:0] next_r = in_rst ? ddir_pkg::ACC_ZERO :
                       inc_r  ? alu_bus.inc_val :
                       wr_r   ? wr_data_i : acc_r;

  // flag update: divide leaves c and o alone
  wire [ddir_pkg::FLAG_W-1:0] div_flags =
    {flags[ddir_pkg::FLAG_C], flags[ddir_pkg::FLAG_O],
     alu_bus.div_s, alu_bus.div_z};
  wire [ddir_pkg::FLAG_W-1:0] inc_flags =
    {alu_bus.inc_c, alu_bus.inc_o,
     alu_bus.inc_s, alu_bus.inc_z};
  wire [ddir_pkg::FLAG_W-1:0] next_flags =
    in_rst ? ddir_pkg::FLAGS_RST :
    do_div ? div_flags :
    do_inc ? inc_flags : flags;

  // re-init sequencer: hold resets, then copy configuration
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ddir_pkg::DDIR_IDLE: begin
        next_cnt = ddir_pkg::CNT_ZERO;
        if (do_init) begin
          next_state = ddir_pkg::DDIR_RST;
        end
      end
      ddir_pkg::DDIR_RST: begin
        next_cnt = cnt + ddir_pkg::CFG_AW'(1);
        if (rst_end) begin
          next_state = ddir_pkg::DDIR_COPY;
          next_cnt   = ddir_pkg::CNT_ZERO;
        end
      end
      ddir_pkg::DDIR_COPY: begin
        next_cnt = cnt + ddir_pkg::CFG_AW'(1);
        if (copy_end) begin
          next_state = ddir_pkg::DDIR_LAST;
          next_cnt   = ddir_pkg::CNT_ZERO;
        end
      end
      ddir_pkg::DDIR_LAST: begin
        next_state = ddir_pkg::DDIR_IDLE;
      end
      default: begin
        next_state = ddir_pkg::DDIR_IDLE;
        next_cnt   = ddir_pkg::CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= ddir_pkg::DDIR_IDLE;
      cnt   <= ddir_pkg::CNT_ZERO;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      acc_a <= ddir_pkg::ACC_ZERO;
      acc_b <= ddir_pkg::ACC_ZERO;
      acc_r <= ddir_pkg::ACC_ZERO;
      flags <= ddir_pkg::FLAGS_RST;
    end else begin
      acc_a <= next_a;
      acc_b <= next_b;
      acc_r <= next_r;
      flags <= next_flags;
    end
  end

  // reset lines to converters and core during the hold phase
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cdc_reset_o                  <= 1'b0;
      resistance_converter_reset_o <= 1'b0;
      cpu_reset_o                  <= 1'b0;
    end else begin
      cdc_reset_o                  <= next_state == ddir_pkg::DDIR_RST;
      resistance_converter_reset_o <= next_state == ddir_pkg::DDIR_RST;
      cpu_reset_o                  <= next_state == ddir_pkg::DDIR_RST;
    end
  end

  // stored settings read then written two cycles later
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      nv_rd_o    <= 1'b0;
      nv_addr_o  <= ddir_pkg::CNT_ZERO;
      rd_q       <= 1'b0;
      rd_addr_q  <= ddir_pkg::CNT_ZERO;
      cfg_we_o   <= 1'b0;
      cfg_addr_o <= ddir_pkg::CNT_ZERO;
      cfg_data_o <= ddir_pkg::CFG_DZERO;
    end else begin
      nv_rd_o    <= next_state == ddir_pkg::DDIR_COPY;
      nv_addr_o  <= next_cnt;
      rd_q       <= nv_rd_o;
      rd_addr_q  <= nv_addr_o;
      cfg_we_o   <= rd_q;
      cfg_addr_o <= rd_addr_q;
      cfg_data_o <= nv_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= next_state != ddir_pkg::DDIR_IDLE;
      done_o <= (state == ddir_pkg::DDIR_LAST);
    end
  end

  assign acc_a_o = acc_a;
  assign acc_b_o = acc_b;
  assign acc_r_o = acc_r;
  assign flags_o = flags;
endmodule : ddir_core

/* File: tb/ddir_core_asserts.sv */
// checker for the divide, increment and re-init core
// assumes it is bound to ddir_core and sees only its ports
`timescale 1ns/100ps
module ddir_core_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        op_valid_i,
  input wire logic [1:0]  op_code_i,
  input wire logic [1:0]  op_sel_i,
  input wire logic [7:0]  nv_data_i,
  input wire logic [31:0] acc_a_o,
  input wire logic [31:0] acc_b_o,
  input wire logic [31:0] acc_r_o,
  input wire logic [3:0]  flags_o,
  input wire logic        busy_o,
  input wire logic        cdc_reset_o,
  input wire logic        resistance_converter_reset_o,
  input wire logic        cpu_reset_o,
  input wire logic        nv_rd_o,
  input wire logic [5:0]  nv_addr_o,
  input wire logic        cfg_we_o,
  input wire logic [5:0]  cfg_addr_o,
  input wire logic [7:0]  cfg_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire        go = op_valid_i && !busy_o;
  wire        dv = go && op_code_i == ddir_pkg::OP_DIV;
  wire        ib = go && op_code_i == ddir_pkg::OP_INC && op_sel_i == 2'h1;
  wire        it = go && op_code_i == ddir_pkg::OP_INIT;
  wire        ge = acc_a_o >= acc_r_o;
  wire [31:0] nx = (ge ? acc_a_o - acc_r_o : acc_a_o) << 1;
  wire [1:0]  co = flags_o[3:2];
  wire        bmax = acc_b_o == 32'hFFFF_FFFF;
  wire        bsm = acc_b_o == ddir_pkg::ACC_SMAX;
  sequence hold_s;
    cdc_reset_o && resistance_converter_reset_o && cpu_reset_o && busy_o;
  endsequence
  sequence copy_s;
    !cpu_reset_o && nv_rd_o && nv_addr_o == 6'h00;
  endsequence
  sequence clr_s;
    acc_a_o == 32'h0 && acc_b_o == 32'h0 && acc_r_o == 32'h0 && flags_o == 4'h0;
  endsequence
  div_quot_a: assert property (dv |=> acc_b_o ==
    (($past(acc_b_o) << 1) | {31'h0, $past(ge)})) else $error("div quotient");
  div_rem_a: assert property (dv |=> acc_a_o == $past(nx))
    else $error("div remainder");
  div_flags_a: assert property (dv |=> flags_o ==
    {$past(co), acc_b_o[31], acc_b_o == 32'h0}) else $error("div flags");
  inc_value_a: assert property (ib |=> acc_b_o == $past(acc_b_o) + 32'h1 &&
    flags_o == {$past(bmax), $past(bsm), acc_b_o[31], acc_b_o == 32'h0})
    else $error("inc result");
  init_hold_a: assert property (it |=> hold_s [*5] ##1 copy_s)
    else $error("reset hold");
  init_clear_a: assert property (it |-> ##2 clr_s [*4])
    else $error("core clear");
  copy_addr_a: assert property (nv_rd_o |-> ##2
    cfg_we_o && cfg_addr_o == $past(nv_addr_o, 2)) else $error("copy addr");
  copy_data_a: assert property (nv_rd_o |-> ##2
    cfg_data_o == $past(nv_data_i)) else $error("copy data");
endmodule : ddir_core_chk

bind ddir_core ddir_core_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_sel_i(op_sel_i),
  .nv_data_i(nv_data_i), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o),
  .acc_r_o(acc_r_o), .flags_o(flags_o), .busy_o(busy_o),
  .cdc_reset_o(cdc_reset_o),
  .resistance_converter_reset_o(resistance_converter_reset_o),
  .cpu_reset_o(cpu_reset_o), .nv_rd_o(nv_rd_o), .nv_addr_o(nv_addr_o),
  .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o));

/* File: tb/testbench.sv */
// self-checking bench for the divide, increment and re-init core
// assumes a 10 MHz clock and stored settings answered one cycle late
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        op_valid_i = 1'b0;
  logic        wr_en_i = 1'b0;
  logic [1:0]  op_code_i = 2'h0, op_sel_i = 2'h0, wr_sel_i = 2'h0;
  logic [31:0] wr_data_i = 32'h0;
  logic [7:0]  nv_data_i = 8'h00;
  logic [31:0] acc_a_o, acc_b_o, acc_r_o;
  logic [3:0]  flags_o;
  logic        busy_o, done_o, cdc_rst, res_rst, cpu_rst, nv_rd_o, cfg_we_o;
  logic        rd;
  logic [5:0]  nv_addr_o, cfg_addr_o, ad;
  logic [7:0]  cfg_data_o;
  int          fails = 0, samples_checked = 0, n_we = 0, n_done = 0;
  always #50 clk_i = ~clk_i;
  ddir_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_sel_i(op_sel_i),
    .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i),
    .nv_data_i(nv_data_i), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o),
    .acc_r_o(acc_r_o), .flags_o(flags_o), .busy_o(busy_o), .done_o(done_o),
    .cdc_reset_o(cdc_rst), .resistance_converter_reset_o(res_rst),
    .cpu_reset_o(cpu_rst), .nv_rd_o(nv_rd_o), .nv_addr_o(nv_addr_o),
    .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o));
  function automatic logic [7:0] nvf(input logic [5:0] x);
    return {2'h0, x} ^ 8'h5A;
  endfunction : nvf
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    op_valid_i = 1'b0;
    wr_en_i = 1'b1;
    wr_sel_i = s;
    wr_data_i = d;
    tick();
  endtask : wr
  task automatic op(input logic [1:0] c, input logic [1:0] s);
    wr_en_i = 1'b0;
    op_valid_i = 1'b1;
    op_code_i = c;
    op_sel_i = s;
    tick();
  endtask : op
  // stored settings answer the cycle after each read strobe
  always @(posedge clk_i) begin
    if (cfg_we_o === 1'b1) begin
      chk({26'h0, cfg_addr_o}, n_we);
      chk({24'h0, cfg_data_o}, {24'h0, nvf(cfg_addr_o)});
      n_we++;
    end
    if (done_o === 1'b1) n_done++;
    ad = nv_addr_o;
    rd = nv_rd_o;
    #1 nv_data_i = rd ? nvf(ad) : ~nv_data_i;
  end
  task automatic t_inc;
    logic [31:0] v [3] = '{32'h7FFF_FFFF, 32'h0000_0005, 32'hFFFF_FFFF};
    logic [31:0] e;
    for (int i = 0; i < 3; i++) begin
      wr(2'(i), v[i]);
      op(ddir_pkg::OP_INC, 2'(i));
      e = v[i] + 32'h1;
      chk(i == 0 ? acc_a_o : i == 1 ? acc_b_o : acc_r_o, e);
      chk({28'h0, flags_o}, {28'h0, v[i] == 32'hFFFF_FFFF,
        v[i] == 32'h7FFF_FFFF, e[31], e == 32'h0});
    end
  endtask : t_inc
  task automatic t_div(input logic [31:0] a0, input logic [31:0] r0);
    logic [63:0] num;
    logic [31:0] q;
    logic [1:0]  co;
    wr(ddir_pkg::SEL_A, a0);
    wr(ddir_pkg::SEL_B, 32'h0);
    wr(ddir_pkg::SEL_R, r0);
    co = flags_o[3:2];
    for (int n = 1; n <= 32; n++) begin
      op(ddir_pkg::OP_DIV, 2'h0);
      num = {32'h0, a0} << (n - 1);
      q = 32'(num / {32'h0, r0});
      chk(acc_b_o, q);
      chk(acc_a_o, 32'(num % {32'h0, r0}) << 1);
      chk({28'h0, flags_o}, {28'h0, co, q[31], q == 32'h0});
    end
  endtask : t_div
  task automatic t_init;
    op(ddir_pkg::OP_INIT, 2'h0);
    op_valid_i = 1'b0;
    chk({29'h0, cdc_rst, res_rst, cpu_rst}, 32'h7);
    chk({31'h0, busy_o}, 32'h1);
    repeat (8) tick();
    chk({29'h0, cdc_rst, res_rst, cpu_rst}, 32'h0);
    // commands and loads during the copy are dropped
    op(ddir_pkg::OP_INC, ddir_pkg::SEL_A);
    wr(ddir_pkg::SEL_R, 32'h0000_1234);
    wr_en_i = 1'b0;
    for (int k = 0; k < 200 && n_done == 0; k++) tick();
    tick();
    chk(n_we, 32'h40);
    chk(n_done, 32'h1);
    chk({31'h0, busy_o}, 32'h0);
    chk(acc_a_o, 32'h0);
    chk(acc_b_o, 32'h0);
    chk(acc_r_o, 32'h0);
    chk({28'h0, flags_o}, 32'h0);
  endtask : t_init
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    t_inc();
    t_div(32'h0000_0005, 32'h0000_0003);
    t_div(32'h0000_0064, 32'h0000_0007 << 3);
    t_init();
    close_out();
  end
  initial begin
    #100000;
    fails++;
    close_out();
  end
endmodule : testbench
